// ==== pkg/sadc_pkg.sv ====
// constants, state type and timing counts of the parallel-readout converter
// assumes one 40 MHz system clock and control inputs synchronous to it
//
// Contract
// RULE_01 - convert strobe low for the minimum pulse width
// RULE_02 - busy low from start until result loaded
// RULE_03 - select and strobe low: hold, start conversion
// RULE_04 - select ORed with strobe, either may fall first
// RULE_05 - host sets other input low 10 ns earlier
// RULE_06 - tracking begins at end; commands 4 us apart
// RULE_07 - strobe fall starts only when idle; rise enables
// RULE_08 - bus driven only for strobe high, select low
// RULE_09 - conversion start leaves or puts bus in hi-z
// RULE_10 - busy rises with result n on bus
// RULE_11 - bus enabled during conversion shows previous result
// RULE_12 - both low at busy rise: invalid restart
// RULE_13 - result is two's complement, msb on top
// RULE_14 - word or two bytes readable per cycle
// RULE_15 - select tied low: strobe alone converts, reads
// RULE_16 - half select low upper byte, high lower
// RULE_17 - internal counter times conversion, load before release
package sadc_pkg;

  localparam int CLK_PERIOD_PS = 25000;
  localparam int PULSE_MIN_NS = 40;
  localparam int SETUP_NS = 10;
  localparam int CONV_TIME_NS = 2000;
  localparam int ACQ_TIME_NS = 2000;
  localparam int CYCLE_TIME_NS = 4000;

  // least times round up, longest times round down
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_CYC = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int ACQ_CYC = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int RES_W = 16;
  localparam int HALF_W = 8;
  localparam int CNT_W = 8;

  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [RES_W-1:0] CODE_POS_FS = 16'h7FFF;
  localparam logic [RES_W-1:0] CODE_NEG_FS = 16'h8000;

  typedef logic [RES_W-1:0] sadc_word_t;

  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_CONV = 2'b01,
    SADC_LOAD = 2'b11,
    SADC_REARM = 2'b10
  } sadc_state_e;

endpackage

// ==== pkg/sadc_tmr_if.sv ====
// start and done of one internal interval timer
// assumes one controller and one timer on the same clock
`timescale 1ns/10ps
interface sadc_tmr_if;
  logic start;
  logic run;
  logic done;

  modport tmr (input start, output run, output done);
  modport ctl (output start, input run, input done);
endinterface

// ==== hdl/sadc_timer.sv ====
// down counter that times one interval of a fixed number of cycles
// assumes start is a one-cycle pulse; a restart while running reloads
`timescale 1ns/10ps
module sadc_timer
  import sadc_pkg::*;
#(
  parameter int LEN = 80
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // control
  sadc_tmr_if.tmr tmr
);

  localparam logic [CNT_W-1:0] LOAD_VAL = CNT_W'(LEN - 1);

  logic [CNT_W-1:0] cnt_reg;
  logic run_reg;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end
    else if (tmr.start)
    begin
      cnt_reg <= LOAD_VAL; // RULE_17
      run_reg <= 1'b1;
    end
    else if (run_reg)
    begin
      if (cnt_reg == '0)
        run_reg <= 1'b0;
      else
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign tmr.run = run_reg;
  assign tmr.done = run_reg && (cnt_reg == '0) && !tmr.start;

endmodule // sadc_timer

// ==== hdl/sadc_byte_mux.sv ====
// arranges the result word on the byte lanes of the output bus
// assumes the caller registers the lanes before they leave the block
`timescale 1ns/10ps
module sadc_byte_mux
  import sadc_pkg::*;
(
  // result and lane choice
  input wire sadc_pkg::sadc_word_t word_i,
  input wire logic half_sel_i,
  // lanes
  output sadc_pkg::sadc_word_t lanes_o
);

  logic [HALF_W-1:0] hi_byte;
  logic [HALF_W-1:0] lo_byte;

  assign hi_byte = word_i[RES_W-1:HALF_W];
  assign lo_byte = word_i[HALF_W-1:0];

  // full word when low; bytes swap when high so either byte is on top
  assign lanes_o = half_sel_i ? {lo_byte, hi_byte} : {hi_byte, lo_byte}; // RULE_16 RULE_14

endmodule // sadc_byte_mux

// ==== hdl/sadc_parallel_if.sv ====
// conversion control and three-state result readout of the converter
// assumes select and strobe are synchronous to clk_sys_i; the
// digitised input value arrives on sample_i
`timescale 1ns/10ps
module sadc_parallel_if
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // host control
  input wire logic sel_n_i,
  input wire logic read_conv_n_i,
  input wire logic half_sel_i,
  // converter core value
  input wire sadc_pkg::sadc_word_t sample_i,
  // status
  output logic busy_n_o,
  output logic hold_o,
  output logic track_o,
  output logic data_invalid_o,
  // result bus
  output sadc_pkg::sadc_word_t result_bus_o,
  output logic result_bus_oe_o
);

  import sadc_pkg::*;

  sadc_tmr_if conv_tmr ();
  sadc_tmr_if acq_tmr ();

  sadc_state_e state_reg;
  sadc_state_e state_next;

  logic comb_n;
  logic comb_prev_reg;
  logic rearm;
  logic in_idle;
  logic start;
  logic short_acq;

  sadc_word_t sample_reg;
  sadc_word_t result_reg;
  sadc_word_t lanes;
  sadc_word_t bus_reg;

  logic busy_n_reg;
  logic hold_reg;
  logic track_reg;
  logic invalid_reg;
  logic oe_next;
  logic oe_reg;

  // select and strobe act as one level-sensitive low-active input
  assign comb_n = sel_n_i | read_conv_n_i; // RULE_04

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      comb_prev_reg <= 1'b1;
    else
      comb_prev_reg <= comb_n;
  end

  // the re-arm state is the first idle cycle after busy has risen
  assign rearm = (state_reg == SADC_REARM);
  assign in_idle = (state_reg == SADC_IDLE) || rearm;

  // a fall of the combined input starts only while idle; a level still
  // low when busy rises restarts at once without fresh acquisition
  always_comb
  begin
    start = 1'b0;
    if (in_idle && !comb_n) // RULE_07
    begin
      if (comb_prev_reg) // RULE_01 RULE_03
        start = 1'b1;
      else if (rearm) // RULE_12
        start = 1'b1;
    end
  end

  // too little tracking time since the last conversion ended
  assign short_acq = acq_tmr.run || rearm; // RULE_06

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SADC_IDLE:
      begin
        if (start)
          state_next = SADC_CONV;
      end
      SADC_CONV:
      begin
        if (conv_tmr.done)
          state_next = SADC_LOAD;
      end
      SADC_LOAD:
      begin
        state_next = SADC_REARM;
      end
      SADC_REARM:
      begin
        // held-low inputs restart here instead of waiting for a fresh fall
        if (start)
          state_next = SADC_CONV;
        else
          state_next = SADC_IDLE;
      end
      default:
      begin
        state_next = SADC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      state_reg <= SADC_IDLE;
    else
      state_reg <= state_next;
  end

  assign conv_tmr.start = start;
  assign acq_tmr.start = (state_reg == SADC_LOAD);

  sadc_timer #(
    .LEN(CONV_CYC)
  ) u_conv_timer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tmr(conv_tmr)
  );

  sadc_timer #(
    .LEN(ACQ_CYC)
  ) u_acq_timer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tmr(acq_tmr)
  );

  // the input is frozen the moment a conversion starts
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      sample_reg <= RESULT_RST;
    else if (start)
      sample_reg <= sample_i; // RULE_03
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      hold_reg <= 1'b0;
    else if (start)
      hold_reg <= 1'b1; // RULE_03
    else if (state_reg == SADC_LOAD)
      hold_reg <= 1'b0; // RULE_06
  end

  // own flop so track_o leaves the block straight from a register
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      track_reg <= 1'b1;
    else if (start)
      track_reg <= 1'b0; // RULE_03
    else if (state_reg == SADC_LOAD)
      track_reg <= 1'b1; // RULE_06
  end

  // the result is already a two's complement code; only the end of
  // conversion may overwrite it, so reads in between see the old one
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      result_reg <= RESULT_RST;
    else if (state_reg == SADC_CONV && conv_tmr.done)
      result_reg <= sample_reg; // RULE_17 RULE_13 RULE_11
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      busy_n_reg <= 1'b1;
    else if (start)
      busy_n_reg <= 1'b0; // RULE_02
    else if (state_reg == SADC_LOAD)
      busy_n_reg <= 1'b1; // RULE_10 RULE_17
  end

  // flagged per conversion; a clean start clears it
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      invalid_reg <= 1'b0;
    else if (start)
      invalid_reg <= short_acq; // RULE_12 RULE_06
  end

  sadc_byte_mux u_byte_mux (
    .word_i(result_reg),
    .half_sel_i(half_sel_i),
    .lanes_o(lanes)
  );

  // lanes follow the result register one cycle late, which lines the
  // new word up with the busy rise
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      bus_reg <= RESULT_RST;
    else
      bus_reg <= lanes; // RULE_10 RULE_14
  end

  // drive only for strobe high and select low; a falling strobe or a
  // start by select both leave the bus released
  always_comb
  begin
    oe_next = 1'b0;
    case ({sel_n_i, read_conv_n_i})
      2'h1:
      begin
        oe_next = 1'b1; // RULE_08 RULE_15 RULE_07
      end
      2'h0:
      begin
        // a start by either pin keeps or puts the lanes in high impedance
        oe_next = 1'b0; // RULE_09
      end
      default:
      begin
        oe_next = 1'b0; // RULE_08
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      oe_reg <= 1'b0;
    else
      oe_reg <= oe_next;
  end

  assign busy_n_o = busy_n_reg;
  assign hold_o = hold_reg;
  assign track_o = track_reg;
  assign data_invalid_o = invalid_reg;
  assign result_bus_o = bus_reg;
  assign result_bus_oe_o = oe_reg;

endmodule // sadc_parallel_if

// ==== testbench/sadc_host_model.sv ====
// host model: drives select, strobe and byte choice
// assumes the bench calls its tasks; lines change at the falling edge
`timescale 1ns/10ps
module sadc_host_model
(
  // clock
  input wire logic clk_sys_i,
  // control lines
  output logic sel_n_o,
  output logic rc_n_o,
  output logic half_o
);
  initial
  begin
    sel_n_o = 1'b1;
    rc_n_o = 1'b1;
    half_o = 1'b0;
  end
  task automatic put(input logic s, input logic r, input logic h);
    @(negedge clk_sys_i);
    sel_n_o = s;
    rc_n_o = r;
    half_o = h;
  endtask
  // two low cycles cover 40 ns; strobe back high before busy rises
  task automatic convert(input bit sel_first);
    put(!sel_first, sel_first, 1'b0);
    put(1'b0, 1'b0, 1'b0);
    put(1'b0, 1'b0, 1'b0);
    put(1'b0, 1'b1, 1'b0);
  endtask
endmodule // sadc_host_model

// ==== testbench/sadc_parallel_if_monitor.sv ====
// assertions on the converter's control and readout ports
// assumes one clock and the synchronous reset of the top module
`timescale 1ns/10ps
module sadc_parallel_if_monitor
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // inputs
  input wire logic sel_n_i,
  input wire logic read_conv_n_i,
  input wire logic half_sel_i,
  input wire sadc_pkg::sadc_word_t sample_i,
  // outputs
  input wire logic busy_n_o,
  input wire logic hold_o,
  input wire logic track_o,
  input wire logic data_invalid_o,
  input wire sadc_pkg::sadc_word_t result_bus_o,
  input wire logic result_bus_oe_o
);
  sadc_word_t bus_q;
  always_ff @(posedge clk_sys_i)
    bus_q <= result_bus_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_word;
    sadc_word_t v;
    ($fell(busy_n_o), v = $past(sample_i)) |->
      ##81 result_bus_o == ($past(half_sel_i) ? {v[7:0], v[15:8]} : v);
  endproperty
  a_bus_enable: assert property (!$past(rst_i) |->
    result_bus_oe_o == (!$past(sel_n_i) && $past(read_conv_n_i))) else $error("bad enable");
  a_start_cause: assert property ($fell(busy_n_o) |->
    hold_o && !track_o && !$past(sel_n_i) && !$past(read_conv_n_i)) else $error("bad start");
  a_busy_length: assert property ($fell(busy_n_o) |->
    (!busy_n_o throughout ##80 1'b1) ##1 busy_n_o) else $error("bad busy length");
  a_release_track: assert property ($rose(busy_n_o) |->
    !hold_o && track_o) else $error("no tracking");
  a_prev_result: assert property (!busy_n_o && !$past(busy_n_o) &&
    $past(half_sel_i) == $past(half_sel_i, 2) |-> $stable(result_bus_o)) else $error("bus moved");
  a_invalid_flag: assert property ($changed(data_invalid_o) |->
    $fell(busy_n_o)) else $error("flag moved");
  a_byte_swap: assert property (busy_n_o && $past(busy_n_o) && !$past(rst_i) &&
    $past(half_sel_i) != $past(half_sel_i, 2) |-> result_bus_o == {bus_q[7:0], bus_q[15:8]})
    else $error("bad lanes");
  a_word_load: assert property (p_word) else $error("bad result");
  c_conv: cover property ($fell(busy_n_o));
  c_restart: cover property ($rose(data_invalid_o));
  c_byte: cover property ($changed(half_sel_i) && result_bus_oe_o);
endmodule // sadc_parallel_if_monitor
bind sadc_parallel_if sadc_parallel_if_monitor mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .sel_n_i(sel_n_i), .read_conv_n_i(read_conv_n_i), .half_sel_i(half_sel_i),
  .sample_i(sample_i), .busy_n_o(busy_n_o), .hold_o(hold_o), .track_o(track_o),
  .data_invalid_o(data_invalid_o), .result_bus_o(result_bus_o),
  .result_bus_oe_o(result_bus_oe_o));

// ==== testbench/sadc_parallel_if_tb.sv ====
// self-checking bench of the converter readout block
// assumes the host model and the bound monitor
`timescale 1ns/10ps
module sadc_parallel_if_tb;
  import sadc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic sel_n, rc_n, half;
  logic busy_n_o, hold_o, track_o, data_invalid_o, result_bus_oe_o;
  sadc_word_t result_bus_o;
  sadc_word_t sample = 16'h0000;
  sadc_word_t prev = 16'h0000;
  sadc_word_t cur;
  sadc_word_t corner [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'h0116;
  always #12.5 clk_sys_i = ~clk_sys_i;
  sadc_host_model host (.clk_sys_i(clk_sys_i), .sel_n_o(sel_n), .rc_n_o(rc_n), .half_o(half));
  sadc_parallel_if dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sel_n_i(sel_n),
    .read_conv_n_i(rc_n), .half_sel_i(half), .sample_i(sample), .busy_n_o(busy_n_o),
    .hold_o(hold_o), .track_o(track_o), .data_invalid_o(data_invalid_o),
    .result_bus_o(result_bus_o), .result_bus_oe_o(result_bus_oe_o));
  function automatic sadc_word_t lanes(input sadc_word_t v, input logic h);
    return h ? {v[7:0], v[15:8]} : v;
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded, so a stuck busy cannot hang the run
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_n_o !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("busy end", 16'(n < 200), 16'h0001);
  endtask
  task automatic one(input sadc_word_t v, input bit sf);
    repeat (160) @(negedge clk_sys_i);
    sample = v;
    host.convert(sf);
    chk("busy", 16'(busy_n_o), 16'h0000);
    chk("hold", 16'({hold_o, track_o}), 16'h0002);
    chk("released", 16'(result_bus_oe_o), 16'h0000);
    chk("invalid", 16'(data_invalid_o), 16'h0000);
    chk("old word", result_bus_o, prev);
    wait_idle();
    chk("track", 16'({hold_o, track_o}), 16'h0001);
    chk("word", result_bus_o, v);
    chk("enable", 16'(result_bus_oe_o), 16'h0001);
    host.put(1'b0, 1'b1, 1'b1);
    @(negedge clk_sys_i);
    chk("low byte", result_bus_o, lanes(v, 1'b1));
    host.put(1'b1, 1'b1, 1'b0);
    @(negedge clk_sys_i);
    chk("hi-z", 16'(result_bus_oe_o), 16'h0000);
    prev = v;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      cur = (i < 4) ? corner[i] : 16'($random(seed));
      one(cur, i[0]);
      $display("test conversion %0d done", i);
    end
    repeat (170) @(negedge clk_sys_i);
    sample = 16'($random(seed));
    host.put(1'b0, 1'b0, 1'b0);
    @(negedge clk_sys_i);
    chk("clean start", 16'(data_invalid_o), 16'h0000);
    wait_idle();
    repeat (2) @(negedge clk_sys_i);
    chk("restart", 16'(data_invalid_o), 16'h0001);
    chk("restart busy", 16'(busy_n_o), 16'h0000);
    host.put(1'b1, 1'b1, 1'b0);
    wait_idle();
    $display("test restart done");
    stop_test();
  end
endmodule // sadc_parallel_if_tb
